// ==== include/byte_alu_pkg.sv ====
// Purpose: Shared constants and types for the byte ALU slice
// Assumes: One instruction per enabled clock, decoder supplies operands
// Notes: Summary of operation list below
//
// Summary of operation
// [RULE1] Subtract: file minus working, two's complement
// [RULE2] Subtract/xor-file: direction picks working or file
// [RULE3] Xor-file: working xor file register
// [RULE4] Swap nibbles of file; flags untouched
// [RULE5] Swap: direction picks working or file
// [RULE6] Xor-literal: working xor literal into working
// [RULE7] Carry/digit carry on subtract; zero on result
package byte_alu_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [6:0] FILE_ADDR_MAX = 7'h7F;
  localparam logic DEST_W = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  localparam int NIB_LO_MSB = 3;
  localparam int NIB_HI_LSB = 4;

  // Operation selector from the decoder
  typedef enum logic [1:0] {
    OP_SUB_W_FROM_FILE,
    OP_XOR_W_WITH_FILE,
    OP_NIBBLE_SWAP_FILE,
    OP_XOR_LITERAL_INTO_W
  } alu_op_type;

  // Instruction presented by the decoder
  typedef struct packed {
    logic valid;
    alu_op_type op;
    logic [6:0] file_addr;
    logic dest;
    logic [7:0] file_data;
    logic [7:0] literal;
  } alu_req_type;

  // Write-back into the file register
  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_type;

  // Status flags
  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } alu_flags_type;
endpackage

// ==== design/byte_alu.sv ====
// Purpose: Byte ALU slice: subtract, xor with file, nibble swap, xor literal
// Assumes: Decoder reads file register combinationally and holds request one cycle
// Notes: Results and flags are registered; file write is a pulse of one enabled cycle
`timescale 1ns/1ps
`default_nettype none
module byte_alu
  import byte_alu_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // Decoder request
  input wire alu_req_type req,
  // Results
  output logic [7:0] w_out,
  output file_wr_type file_wr,
  output alu_flags_type flags
);

  ////////////////////////////////////////////////////////////////////////
  // Block state is one packed struct
  typedef struct packed {
    logic [7:0] w;
    file_wr_type fw;
    alu_flags_type fl;
  } state_type;

  state_type state_reg; // Registered state
  state_type state_next; // Next state
  logic [8:0] diff; // Nine bits so the borrow shows
  logic [4:0] diff_lo; // Low nibble borrow
  logic [7:0] result; // Operation result

  // Zero test used for every flag-setting operation
  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Datapath and write-back selection
  always_comb begin
    // Only the write strobe defaults low; all else holds its value
    state_next = state_reg;
    state_next.fw.we = 1'b0; // Write strobe lasts one enabled cycle
    diff = {1'b0, req.file_data} - {1'b0, state_reg.w}; // [RULE1]
    diff_lo = {1'b0, req.file_data[3:0]} - {1'b0, state_reg.w[3:0]};
    result = 8'h00;
    if (req.valid) begin
      unique case (req.op)
        OP_SUB_W_FROM_FILE: begin
          result = diff[7:0]; // [RULE1]
          state_next.fl.carry = ~diff[8]; // No borrow means W <= f [RULE7]
          state_next.fl.digit_carry_flag = ~diff_lo[4]; // [RULE7]
          state_next.fl.zero = is_zero(result); // [RULE7]
        end
        OP_XOR_W_WITH_FILE: begin
          result = state_reg.w ^ req.file_data; // [RULE3]
          state_next.fl.zero = is_zero(result); // [RULE7]
        end
        OP_NIBBLE_SWAP_FILE: begin
          // Flags left alone on purpose
          result = {req.file_data[NIB_LO_MSB:0], req.file_data[7:NIB_HI_LSB]}; // [RULE4]
        end
        OP_XOR_LITERAL_INTO_W: begin
          result = state_reg.w ^ req.literal; // [RULE6]
          state_next.fl.zero = is_zero(result); // [RULE7]
        end
      endcase
      // Literal form always lands in the working register
      if (req.op == OP_XOR_LITERAL_INTO_W || req.dest == DEST_W) begin
        state_next.w = result; // [RULE2] [RULE5] [RULE6]
      end else begin
        state_next.fw.we = 1'b1; // [RULE2] [RULE5]
        state_next.fw.addr = req.file_addr;
        state_next.fw.data = result;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register, frozen while the clock enable is low
  // Reset wins over the clock enable, so a frozen core still clears
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= '{w: W_RESET, fw: '0, fl: '0};
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from the state flip-flops, no logic after them
  assign w_out = state_reg.w;
  assign file_wr = state_reg.fw;
  assign flags = state_reg.fl;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Every check is cut off while reset is high
  // Subtract into W gives f minus the previous W
  property p_sub_result;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && req.valid && req.op == OP_SUB_W_FROM_FILE && req.dest == DEST_W)
        |=> w_out == $past(req.file_data) - $past(w_out);
  endproperty
  a_sub_result: assert property (p_sub_result) else $error("sub result wrong"); // [RULE1]

  // A file destination pulses the write and keeps W
  property p_file_dest;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && req.valid && req.op != OP_XOR_LITERAL_INTO_W && req.dest == DEST_FILE)
        |=> file_wr.we && file_wr.addr == $past(req.file_addr) && $stable(w_out);
  endproperty
  a_file_dest: assert property (p_file_dest) else $error("file write missing"); // [RULE2]

  // W is unchanged here, so its current value is the operand
  property p_xor_file;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && req.valid && req.op == OP_XOR_W_WITH_FILE && req.dest == DEST_FILE)
        |=> file_wr.data == ($past(req.file_data) ^ w_out);
  endproperty
  a_xor_file: assert property (p_xor_file) else $error("xor file wrong"); // [RULE3]

  // Swap must not touch any flag
  property p_swap;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && req.valid && req.op == OP_NIBBLE_SWAP_FILE)
        |=> $stable(flags);
  endproperty
  a_swap: assert property (p_swap) else $error("swap changed flags"); // [RULE4]

  // Swap into W exchanges the nibbles and writes no file
  property p_swap_w;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && req.valid && req.op == OP_NIBBLE_SWAP_FILE && req.dest == DEST_W)
        |=> w_out == {$past(req.file_data[3:0]), $past(req.file_data[7:4])} && !file_wr.we;
  endproperty
  a_swap_w: assert property (p_swap_w) else $error("swap to w wrong"); // [RULE5]

  // Literal xor always lands in W, whatever the direction bit says
  property p_xor_lit;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && req.valid && req.op == OP_XOR_LITERAL_INTO_W)
        |=> w_out == ($past(w_out) ^ $past(req.literal)) && !file_wr.we;
  endproperty
  a_xor_lit: assert property (p_xor_lit) else $error("xor literal wrong"); // [RULE6]

  // Carry and digit carry mean no borrow out of the byte or nibble
  property p_carry;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && req.valid && req.op == OP_SUB_W_FROM_FILE)
        |=> flags.carry == ($past(w_out) <= $past(req.file_data))
            && flags.digit_carry_flag == ($past(w_out[3:0]) <= $past(req.file_data[3:0]));
  endproperty
  a_carry: assert property (p_carry) else $error("carry flags wrong"); // [RULE7]

  // Zero follows the literal xor result
  property p_zero;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && req.valid && req.op == OP_XOR_LITERAL_INTO_W)
        |=> flags.zero == (w_out == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong"); // [RULE7]

  // Subtract with file destination writes f minus W and leaves W alone
  property p_sub_file;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && req.valid && req.op == OP_SUB_W_FROM_FILE && req.dest == DEST_FILE)
        |=> file_wr.data == $past(req.file_data) - w_out && $stable(w_out);
  endproperty
  a_sub_file: assert property (p_sub_file) else $error("sub to file wrong"); // [RULE2]

  // Xor with file into W
  property p_xor_w;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && req.valid && req.op == OP_XOR_W_WITH_FILE && req.dest == DEST_W)
        |=> w_out == ($past(w_out) ^ $past(req.file_data)) && !file_wr.we;
  endproperty
  a_xor_w: assert property (p_xor_w) else $error("xor to w wrong"); // [RULE3]

  // Swap into the file writes the exchanged nibbles and keeps W
  property p_swap_file;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && req.valid && req.op == OP_NIBBLE_SWAP_FILE && req.dest == DEST_FILE)
        |=> file_wr.we && file_wr.data == {$past(req.file_data[3:0]),
            $past(req.file_data[7:4])} && $stable(w_out);
  endproperty
  a_swap_file: assert property (p_swap_file) else $error("swap to file wrong"); // [RULE5]

  // Zero after subtract or xor with file follows whichever result was written
  property p_zero_file;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && req.valid && (req.op == OP_SUB_W_FROM_FILE || req.op == OP_XOR_W_WITH_FILE))
        |=> flags.zero == (file_wr.we ? file_wr.data == 8'h00 : w_out == 8'h00);
  endproperty
  a_zero_file: assert property (p_zero_file) else $error("zero flag wrong on file op"); // [RULE7]

  // Both xor forms leave carry and digit carry as they were
  property p_xor_keep;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && req.valid && (req.op == OP_XOR_W_WITH_FILE || req.op == OP_XOR_LITERAL_INTO_W))
        |=> $stable(flags.carry) && $stable(flags.digit_carry_flag);
  endproperty
  a_xor_keep: assert property (p_xor_keep) else $error("xor changed carry"); // [RULE7]

  // An idle enabled cycle writes nothing and keeps W and flags
  property p_idle;
    @(posedge clk_sys) disable iff (rst)
      (clk_en && !req.valid)
        |=> !file_wr.we && $stable(w_out) && $stable(flags);
  endproperty
  a_idle: assert property (p_idle) else $error("idle cycle changed state"); // [RULE2]

  // A frozen cycle holds every output, a pending write pulse included
  property p_freeze;
    @(posedge clk_sys) disable iff (rst)
      !clk_en
        |=> $stable(w_out) && $stable(flags) && $stable(file_wr);
  endproperty
  a_freeze: assert property (p_freeze) else $error("frozen cycle changed state"); // [RULE2]

endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Purpose: Self-checking bench for the byte ALU slice
// Assumes: Latency of one enabled edge, W forwarded from the previous result
// Notes: Expected W, flags and file write are tracked by a small model here
`timescale 1ns/1ps
`default_nettype none
module tb
  import byte_alu_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////////
  // Design hook-up
  logic clk_sys;
  logic rst;
  logic clk_en;
  alu_req_type req;
  logic [7:0] w_out;
  file_wr_type file_wr;
  alu_flags_type flags;
  // Bench model of the outputs
  logic [7:0] w_exp;
  alu_flags_type flg_exp;
  file_wr_type fw_exp;
  int err_count;
  int cmp_count;

  byte_alu dut (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .req(req),
    .w_out(w_out), .file_wr(file_wr), .flags(flags)
  );

  // Free-running 20 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare seen against expected: W, flags, then the file write
  task automatic chk(input logic [26:0] seen, input logic [26:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  // One instruction, started at a rising edge: drive, model, compare, idle edge
  task automatic run(alu_op_type o, logic [6:0] a, logic d, logic [7:0] f, logic [7:0] k,
                     bit frz = 1'b0);
    logic [7:0] res;
    req <= '{1'b1, o, a, d, f, k};
    case (o)
      OP_SUB_W_FROM_FILE: begin
        res = f - w_exp;
        flg_exp.carry = (w_exp <= f);
        flg_exp.digit_carry_flag = (w_exp[3:0] <= f[3:0]);
      end
      OP_XOR_W_WITH_FILE: res = w_exp ^ f;
      OP_NIBBLE_SWAP_FILE: res = {f[3:0], f[7:4]};
      default: res = w_exp ^ k;
    endcase
    // Swap leaves every flag alone
    if (o != OP_NIBBLE_SWAP_FILE) begin
      flg_exp.zero = (res == 8'h00);
    end
    // Literal form always lands in W, whatever the direction bit says
    fw_exp.we = d && (o != OP_XOR_LITERAL_INTO_W);
    if (fw_exp.we) begin
      fw_exp.addr = a;
      fw_exp.data = res;
    end else begin
      w_exp = res;
    end
    @(posedge clk_sys);
    // Request taken; optionally freeze with a live request still offered
    if (frz) begin
      clk_en <= 1'b0;
      req <= '{1'b1, OP_XOR_LITERAL_INTO_W, 7'h00, 1'b0, 8'h00, 8'hFF};
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({w_out, flags, file_wr}, {w_exp, flg_exp, fw_exp});
      @(posedge clk_sys);
      clk_en <= 1'b1;
    end
    req.valid <= 1'b0;
    @(negedge clk_sys);
    chk({w_out, flags, file_wr}, {w_exp, flg_exp, fw_exp});
    @(posedge clk_sys);
    // The idle edge ends the write pulse
    fw_exp.we = 1'b0;
  endtask

  // Verdict and end of run
  task automatic final_report();
    if (err_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, operations each followed by an idle edge, a frozen stretch, then a last literal xor
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    req = '0;
    w_exp = 8'h00;
    flg_exp = '0;
    fw_exp = '0;
    err_count = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk({w_out, flags, file_wr}, {w_exp, flg_exp, fw_exp});
    @(posedge clk_sys);
    run(OP_XOR_LITERAL_INTO_W, 7'h00, 1'b0, 8'h00, 8'h01);
    run(OP_SUB_W_FROM_FILE, 7'h05, 1'b1, 8'h10, 8'h00);
    run(OP_SUB_W_FROM_FILE, 7'h00, 1'b0, 8'h01, 8'h00);
    run(OP_XOR_LITERAL_INTO_W, 7'h00, 1'b0, 8'h00, 8'hFF);
    run(OP_SUB_W_FROM_FILE, 7'h7F, 1'b0, 8'h7E, 8'h00);
    run(OP_XOR_W_WITH_FILE, 7'h7F, 1'b1, 8'h7F, 8'h00);
    run(OP_XOR_W_WITH_FILE, 7'h11, 1'b0, 8'h80, 8'h00);
    run(OP_NIBBLE_SWAP_FILE, 7'h22, 1'b0, 8'hA5, 8'h00);
    // Frozen clock enable must ignore a valid request and hold the pulse
    run(OP_NIBBLE_SWAP_FILE, 7'h40, 1'b1, 8'h3C, 8'h00, 1'b1);
    @(negedge clk_sys);
    chk({w_out, flags, file_wr}, {w_exp, flg_exp, fw_exp});
    @(posedge clk_sys);
    run(OP_XOR_LITERAL_INTO_W, 7'h33, 1'b1, 8'h00, 8'h5A);
    final_report();
  end
endmodule
`default_nettype wire
